/* cod_pkg.sv */
// Package for the clock output mode and delay configuration block.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register master.
//
// Function
// - Each output follows its function select: clock, SYSREF, or request passthrough.
// - Function select 3 gives pulsed SYSREF bursts on SYSREF requests, not continuous SYSREF.
// - Request accept enable 0 makes an output ignore request pulses and run freely; passthrough still follows the request level.
// - Coarse delay counts in half VCO periods per code.
// - A delay code equal to the divide ratio shifts by half the output period.
// - Fault status is high when any masked flag (bits 5, 3, 1) asserts.
// - Pulsed SYSREF gives two to the pulse count exponent pulses per SYSREF request.
// - Request type select: 0 means synchronisation, 1 means SYSREF request.

`default_nettype none

package cod_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_OUT  = 11;
  localparam int DIV_W    = 12;
  localparam int DEL_W    = 12;
  localparam int CNT_W    = 13;

  // ---------------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_MASK   = 8'h01;
  localparam logic [7:0] IDX_PWR    = 8'h02;
  localparam logic [7:0] IDX_PDA    = 8'h03;
  localparam logic [7:0] IDX_PDB    = 8'h04;
  localparam logic [7:0] IDX_PDC    = 8'h05;
  localparam logic [7:0] IDX_GLOB   = 8'h06;
  localparam logic [7:0] IDX_FLAGS  = 8'h07;
  localparam logic [7:0] IDX_IRQST  = 8'h08;
  localparam logic [7:0] IDX_IRQMSK = 8'h09;
  localparam logic [7:0] IDX_OUT0   = 8'h10;
  localparam logic [7:0] IDX_DIV0   = 8'h20;
  localparam logic [7:0] IDX_DEL0   = 8'h30;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MASK_LOCK_BIT = 5;
  localparam int MASK_VCO_BIT  = 3;
  localparam int MASK_REF_BIT  = 1;
  localparam int GLOB_SRQ_BIT  = 0;
  localparam int GLOB_MD_BIT   = 1;
  localparam int GLOB_PAR_BIT  = 2;
  localparam int GLOB_RAO_BIT  = 3;
  localparam int GLOB_CT_LSB   = 4;
  localparam int IRQ_SYNC_BIT  = 0;
  localparam int IRQ_SREQ_BIT  = 1;
  localparam int IRQ_FLT_BIT   = 2;

  // ---------------------------------------------------------------------------
  // Reset values and function codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [DIV_W-1:0] RST_DIV = 12'h001;
  localparam logic [1:0]  FN_CLOCK  = 2'h0;
  localparam logic [1:0]  FN_SYSREF = 2'h1;
  localparam logic [1:0]  FN_PASS   = 2'h2;
  localparam logic [1:0]  FN_PULSED = 2'h3;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Per-output configuration carried to the channel.
  typedef struct packed {
    logic [1:0]       output_function_select;
    logic             request_accept_enable;
    logic [1:0]       output_power_level;
    logic [DIV_W-1:0] output_divide_ratio;
    logic [DEL_W-1:0] coarse_delay_code;
  } cod_cfg_t;

  // Global request controls shared by all channels.
  typedef struct packed {
    logic       sync_pulse;
    logic       sysref_pulse;
    logic       pass_level;
    logic [2:0] pulse_count_exponent;
  } cod_req_t;

endpackage : cod_pkg

`default_nettype wire

/* cod_sync3.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to aclk.

`timescale 1ns/10ps
`default_nettype none

module cod_sync3
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output var  logic dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ---------------------------------------------------------------------------
  // Chain
  // ---------------------------------------------------------------------------
  // The first stage feeds only the second; a change counts once stages agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end

endmodule : cod_sync3

`default_nettype wire

/* cod_channel.sv */
// One output channel: divider, coarse delay and function select.
// Assumes one aclk enable per half VCO cycle (vco_half_en) from the top.

`timescale 1ns/10ps
`default_nettype none

module cod_channel
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             vco_half_en,
  input  wire cod_pkg::cod_cfg_t cfg,
  input  wire cod_pkg::cod_req_t req,
  output var  logic             clk_out,
  output var  logic             busy
);

  typedef enum logic [1:0] {CH_RUN, CH_WAIT, CH_BURST} cod_ch_state_t;

  cod_ch_state_t                     st_r;
  logic [cod_pkg::DEL_W-1:0]         dly_r;
  logic [cod_pkg::DIV_W-1:0]         ph_r;
  logic                              div_r;
  logic [cod_pkg::CNT_W-1:0]         edges_r;
  logic                              bursting_r;

  // Request decode; a disabled channel ignores sync and SYSREF pulses, but passthrough still follows pass_level.
  wire accept    = cfg.request_accept_enable;
  wire sync_hit  = accept && req.sync_pulse;
  wire is_pulsed = (cfg.output_function_select == cod_pkg::FN_PULSED);
  wire sref_hit  = accept && req.sysref_pulse && is_pulsed;
  wire [cod_pkg::DIV_W-1:0] last_ph = cfg.output_divide_ratio - 12'h001;
  // Two edges per pulse, so 2^exp pulses need 2^(exp+1) half-period edges.
  wire [cod_pkg::CNT_W-1:0] burst_edges = 13'h0002 << req.pulse_count_exponent;
  wire ratio_ok  = (cfg.output_divide_ratio != 12'h000);

  // ---------------------------------------------------------------------------
  // Divider and delay sequencer
  // ---------------------------------------------------------------------------
  // The divider toggles every output_divide_ratio half VCO cycles, so a delay
  // equal to the ratio lands exactly half an output period later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r       <= CH_RUN;
      dly_r      <= '0;
      ph_r       <= '0;
      div_r      <= 1'b0;
      edges_r    <= '0;
      bursting_r <= 1'b0;
    end
    else if (sync_hit || sref_hit)
    begin
      st_r       <= CH_WAIT;
      dly_r      <= cfg.coarse_delay_code;
      ph_r       <= '0;
      div_r      <= 1'b0;
      bursting_r <= sref_hit;
      edges_r    <= burst_edges;
    end
    else if (vco_half_en)
    begin
      unique case (st_r)
        CH_WAIT:
        begin
          if (dly_r == '0)
            st_r <= bursting_r ? CH_BURST : CH_RUN;
          else
            dly_r <= dly_r - 12'h001;
        end
        CH_RUN, CH_BURST:
        begin
          if (ratio_ok && ph_r >= last_ph)
          begin
            ph_r  <= '0;
            div_r <= ~div_r;
            if (st_r == CH_BURST)
            begin
              edges_r <= edges_r - 13'h0001;
              if (edges_r == 13'h0001)
                st_r <= CH_RUN;
            end
          end
          else
            ph_r <= ph_r + 12'h001;
        end
        default: st_r <= CH_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Output function select
  // ---------------------------------------------------------------------------
  // Output moves only on half-VCO steps, so a restart or rewrite leaves no runt.
  wire muted = (cfg.output_power_level == 2'h3);
  logic sel;
  always_comb
  begin
    unique case (cfg.output_function_select)
      cod_pkg::FN_CLOCK:  sel = div_r;
      cod_pkg::FN_SYSREF: sel = div_r;
      cod_pkg::FN_PASS:   sel = req.pass_level;
      cod_pkg::FN_PULSED: sel = (st_r == CH_BURST) && div_r;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_out <= 1'b0;
      busy    <= 1'b0;
    end
    else
    begin
      if (vco_half_en)
        clk_out <= sel && !muted;
      busy    <= (st_r != CH_RUN);
    end
  end

endmodule : cod_channel

`default_nettype wire

/* cod_top.sv */
// Top of the clock output mode and delay configuration block.
// Assumes an AXI4-Lite master, asynchronous request and flag pins, and a
// half-VCO-cycle enable modelled by a divider of aclk.
//
// Register access over AXI4-Lite was left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module cod_top
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    sync_request_input,
  input  wire logic                    lock_flag_in,
  input  wire logic                    vco_present_flag_in,
  input  wire logic                    reference_present_flag_in,
  output var  logic [cod_pkg::NUM_OUT-1:0] clk_outs,
  output var  logic                    fault_status,
  output var  logic                    irq
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]                 mask_r;
  logic [7:0]                 pwr_r;
  logic [7:0]                 pda_r;
  logic [7:0]                 pdb_r;
  logic [7:0]                 pdc_r;
  logic [7:0]                 glob_r;
  logic [2:0]                 irq_st_r;
  logic [2:0]                 irq_msk_r;
  logic [3:0]                 mode_r [cod_pkg::NUM_OUT];
  logic [cod_pkg::DIV_W-1:0]  div_r  [cod_pkg::NUM_OUT];
  logic [cod_pkg::DEL_W-1:0]  del_r  [cod_pkg::NUM_OUT];
  logic [7:0]                 aw_r;
  logic                       aw_ok_r;
  logic [31:0]                wd_r;
  logic                       wd_ok_r;
  logic                       req_prev_r;
  logic                       vco_half_r;

  logic                       pin_req;
  logic                       lock_s;
  logic                       vco_s;
  logic                       ref_s;
  logic [cod_pkg::NUM_OUT-1:0] busy;
  logic [cod_pkg::NUM_OUT-1:0] ch_out;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  cod_sync3 u_sync_req (.aclk(aclk), .aresetn(aresetn), .din(sync_request_input), .dout(pin_req));
  cod_sync3 u_sync_lck (.aclk(aclk), .aresetn(aresetn), .din(lock_flag_in), .dout(lock_s));
  cod_sync3 u_sync_vco (.aclk(aclk), .aresetn(aresetn), .din(vco_present_flag_in), .dout(vco_s));
  cod_sync3 u_sync_ref (.aclk(aclk), .aresetn(aresetn), .din(reference_present_flag_in), .dout(ref_s));

  // ---------------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------------
  // Pin and soft request are ORed; the rising edge makes the pulses, the level drives passthrough.
  wire req_level = pin_req | glob_r[cod_pkg::GLOB_SRQ_BIT];
  wire req_rise  = req_level && !req_prev_r;
  wire md        = glob_r[cod_pkg::GLOB_MD_BIT];
  cod_pkg::cod_req_t req;
  assign req.sync_pulse           = req_rise && !md;
  assign req.sysref_pulse         = req_rise && md;
  assign req.pass_level           = req_level;
  assign req.pulse_count_exponent = glob_r[cod_pkg::GLOB_CT_LSB +: 3];

  // Soft request held by software; its edge makes the pulses and its level drives passthrough.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_prev_r <= 1'b0;
      vco_half_r <= 1'b0;
    end
    else
    begin
      req_prev_r <= req_level;
      vco_half_r <= ~vco_half_r;  // Half VCO step modelled at half aclk rate.
    end
  end

  // ---------------------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------------------
  // Power levels pack two bits per output over the three power-down bytes.
  wire [23:0] pd_all = {pdc_r, pdb_r, pda_r};
  genvar g;
  generate
    for (g = 0; g < cod_pkg::NUM_OUT; g++)
    begin : g_ch
      cod_pkg::cod_cfg_t cfg;
      assign cfg.output_function_select = mode_r[g][1:0];
      assign cfg.request_accept_enable  = mode_r[g][2];
      assign cfg.output_power_level     = pd_all[2*g +: 2];
      assign cfg.output_divide_ratio    = div_r[g];
      assign cfg.coarse_delay_code      = del_r[g];
      cod_channel u_ch
      (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .vco_half_en (vco_half_r),
        .cfg         (cfg),
        .req         (req),
        .clk_out     (ch_out[g]),
        .busy        (busy[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Fault and interrupt
  // ---------------------------------------------------------------------------
  wire fault_nxt = (mask_r[cod_pkg::MASK_LOCK_BIT] && lock_s)
                 | (mask_r[cod_pkg::MASK_VCO_BIT]  && vco_s)
                 | (mask_r[cod_pkg::MASK_REF_BIT]  && ref_s);
  wire [2:0] irq_ev = {fault_nxt && !fault_status, req.sysref_pulse, req.sync_pulse};

  // ---------------------------------------------------------------------------
  // AXI4-Lite decode
  // ---------------------------------------------------------------------------
  wire        wr_go   = aw_ok_r && wd_ok_r && !s_axi_bvalid;
  wire [5:0]  wi      = aw_r[7:2];
  wire [5:0]  ri      = s_axi_araddr[7:2];
  wire [3:0]  wsub    = wi[3:0];
  wire [3:0]  rsub    = ri[3:0];
  wire        w_out   = (wi[5:4] != 2'h0) && (wsub < 4'd11);
  wire        r_out   = (ri[5:4] != 2'h0) && (rsub < 4'd11);
  wire        w_ctl   = (wi[5:4] == 2'h0) && (wi >= 6'(cod_pkg::IDX_MASK)) && (wi <= 6'(cod_pkg::IDX_IRQMSK));
  wire        r_ctl   = (ri[5:4] == 2'h0) && (ri >= 6'(cod_pkg::IDX_MASK)) && (ri <= 6'(cod_pkg::IDX_IRQMSK));
  wire        w_hit   = w_out || w_ctl;
  wire        r_hit   = r_out || r_ctl;
  wire [3:0]  rsel    = (rsub < 4'd11) ? rsub : 4'h0;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (ri[5:4])
      2'h1: rd_mux = {27'h0, busy[rsel], mode_r[rsel]};
      2'h2: rd_mux = {20'h0, div_r[rsel]};
      2'h3: rd_mux = {20'h0, del_r[rsel]};
      2'h0:
        unique case (ri)
          6'(cod_pkg::IDX_MASK):   rd_mux = {24'h0, mask_r};
          6'(cod_pkg::IDX_PWR):    rd_mux = {24'h0, pwr_r};
          6'(cod_pkg::IDX_PDA):    rd_mux = {24'h0, pda_r};
          6'(cod_pkg::IDX_PDB):    rd_mux = {24'h0, pdb_r};
          6'(cod_pkg::IDX_PDC):    rd_mux = {24'h0, pdc_r};
          6'(cod_pkg::IDX_GLOB):   rd_mux = {24'h0, glob_r};
          6'(cod_pkg::IDX_FLAGS):  rd_mux = {29'h0, lock_s, vco_s, ref_s};
          6'(cod_pkg::IDX_IRQST):  rd_mux = {29'h0, irq_st_r};
          6'(cod_pkg::IDX_IRQMSK): rd_mux = {29'h0, irq_msk_r};
          default:                 rd_mux = 32'h0000_0000;
        endcase
    endcase
  end

  // Address and data channels are latched independently, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_r <= 1'b0;
      wd_ok_r <= 1'b0;
      aw_r    <= 8'h00;
      wd_r    <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        aw_r    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_ok_r <= 1'b1;
        wd_r    <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_ok_r <= 1'b0;
        wd_ok_r <= 1'b0;
      end
    end
  end

  // Handshake outputs, one transaction of each kind at a time.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cod_pkg::RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= cod_pkg::RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= !aw_ok_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wd_ok_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? cod_pkg::RESP_OK : cod_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= r_hit ? rd_mux : '0;
        s_axi_rresp  <= r_hit ? cod_pkg::RESP_OK : cod_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Byte lane 0 carries the 8-bit registers; lanes 0 and 1 the 12-bit ones.
  logic s_axi_wstrb_q0;
  logic s_axi_wstrb_q1;
  wire wr_b0 = wr_go && s_axi_wstrb_q0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wstrb_q0 <= 1'b0;
      s_axi_wstrb_q1 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wstrb_q0 <= s_axi_wstrb[0];
      s_axi_wstrb_q1 <= s_axi_wstrb[1];
    end
  end

  // Software is expected to zero power, power-down and sync option bytes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_r    <= cod_pkg::RST_BYTE;
      pwr_r     <= cod_pkg::RST_BYTE;
      pda_r     <= cod_pkg::RST_BYTE;
      pdb_r     <= cod_pkg::RST_BYTE;
      pdc_r     <= cod_pkg::RST_BYTE;
      glob_r    <= cod_pkg::RST_BYTE;
      irq_msk_r <= 3'h0;
    end
    else if (wr_b0 && w_ctl)
    begin
      unique case (wi)
        6'(cod_pkg::IDX_MASK):   mask_r    <= wd_r[7:0];
        6'(cod_pkg::IDX_PWR):    pwr_r     <= wd_r[7:0];
        6'(cod_pkg::IDX_PDA):    pda_r     <= wd_r[7:0];
        6'(cod_pkg::IDX_PDB):    pdb_r     <= wd_r[7:0];
        6'(cod_pkg::IDX_PDC):    pdc_r     <= wd_r[7:0];
        6'(cod_pkg::IDX_GLOB):   glob_r    <= wd_r[7:0];
        6'(cod_pkg::IDX_IRQMSK): irq_msk_r <= wd_r[2:0];
        default:                 mask_r    <= mask_r;
      endcase
    end
  end

  // Per-output tables; one generate entry per output.
  generate
    for (g = 0; g < cod_pkg::NUM_OUT; g++)
    begin : g_reg
      wire sel = wr_go && w_out && (wsub == 4'(g));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          mode_r[g] <= 4'h4;
          div_r[g]  <= cod_pkg::RST_DIV;
          del_r[g]  <= '0;
        end
        else if (sel)
        begin
          if (wi[5:4] == 2'h1 && s_axi_wstrb_q0)
            mode_r[g] <= wd_r[3:0];
          if (wi[5:4] == 2'h2 && s_axi_wstrb_q0 && s_axi_wstrb_q1)
            div_r[g] <= wd_r[11:0];
          if (wi[5:4] == 2'h3 && s_axi_wstrb_q0 && s_axi_wstrb_q1)
            del_r[g] <= wd_r[11:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Sticky status, fault pin and outputs
  // ---------------------------------------------------------------------------
  // Set wins over a write-one clear arriving in the same cycle.
  wire clr_st = wr_b0 && w_ctl && (wi == 6'(cod_pkg::IDX_IRQST));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_r     <= 3'h0;
      fault_status <= 1'b0;
      irq          <= 1'b0;
      clk_outs     <= '0;
    end
    else
    begin
      irq_st_r     <= (irq_st_r & ~(clr_st ? wd_r[2:0] : 3'h0)) | irq_ev;
      fault_status <= fault_nxt;
      irq          <= |(irq_st_r & irq_msk_r);
      clk_outs     <= ch_out;
    end
  end

endmodule : cod_top

`default_nettype wire

/* cod_top_props.sv */
// Port checker for cod_top, bound to every instance.
// Assumes one aclk domain whose reset is synchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module cod_props
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        lock_flag_in,
  input wire logic        vco_present_flag_in,
  input wire logic        reference_present_flag_in,
  input wire logic [10:0] clk_outs,
  input wire logic        fault_status,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers hold while the master stalls, and one answer never runs into the next.
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rh: assert property (p_rh) else $error("rvalid dropped");
  property p_b1; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b1: assert property (p_b1) else $error("extra bvalid");
  property p_r1; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r1: assert property (p_r1) else $error("extra rvalid");
  property p_rst; disable iff (1'b0) !aresetn |=> !fault_status && !irq && clk_outs == '0; endproperty
  a_rst: assert property (p_rst) else $error("output live in reset");
  property p_q; (!lock_flag_in && !vco_present_flag_in && !reference_present_flag_in) [*8] |=> !fault_status; endproperty
  a_q: assert property (p_q) else $error("fault without flag");
  property p_s3; $changed(clk_outs[3]) |=> $stable(clk_outs[3]); endproperty
  a_s3: assert property (p_s3) else $error("clock step too short");
  property p_s0; $changed(clk_outs[0]) |=> $stable(clk_outs[0]); endproperty
  a_s0: assert property (p_s0) else $error("pulse step too short");
endmodule : cod_props
bind cod_top cod_props i_cod_props (.*);
`default_nettype wire

/* cod_far_model.sv */
// Receiver model: counts rising edges on every clock output.
// Assumes outputs are sampled on aclk, as a registered receiver would.
`timescale 1ns/10ps
`default_nettype none
module cod_far_model
(
  input wire logic                        aclk,
  input wire logic                        clr,
  input wire logic [cod_pkg::NUM_OUT-1:0] clk_outs,
  output var int                          cnt [cod_pkg::NUM_OUT]
);
  logic [cod_pkg::NUM_OUT-1:0] prev_r;
  // Clearing opens a fresh window, so old edges never leak into a burst count.
  always_ff @(posedge aclk)
  begin
    prev_r <= clk_outs;
    for (int i = 0; i < cod_pkg::NUM_OUT; i++)
      cnt[i] <= clr ? 0 : cnt[i] + int'(clk_outs[i] && !prev_r[i]);
  end
endmodule : cod_far_model
`default_nettype wire

/* clock_output_mode_delay_config_tb_top.sv */
// Self-checking bench for cod_top with a receiver model on its outputs.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
`default_nettype none
module clock_output_mode_delay_config_tb_top;
  logic        aclk, aresetn, clr, sync_request_input, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, lock_flag_in, vco_present_flag_in, reference_present_flag_in;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_status, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, m;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  f;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] clk_outs;
  int          cnt [cod_pkg::NUM_OUT];
  int          n_fail, cmp_count, e, t;
  cod_top i_cod_top (.*);
  cod_far_model i_cod_far_model (.*);
  always #20 aclk = ~aclk;
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic lim(input int n);
    n_fail += int'(n >= 64);
    if (n >= 64) tally_and_finish();
  endtask : lim
  // Address and data go out together; each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    for (n = 0; n < 64 && !(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid); n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    lim(n);
    chk("bresp", s_axi_bresp, 0);
    cyc(2);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (n = 0; n < 64 && !(s_axi_rvalid && !s_axi_arvalid); n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    lim(n);
    chk("read", {s_axi_rresp, s_axi_rdata[29:0]}, {er, ed[29:0]});
    cyc(2);
  endtask : rdc
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic fx(input logic [31:0] mk, input logic [2:0] fl);
    return (mk[5] & fl[2]) | (mk[3] & fl[1]) | (mk[1] & fl[0]);
  endfunction : fx
  task automatic tally_and_finish();
    $display("Compared %0d, mismatched %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence: reset values, request handling, then status and interrupt.
  initial
  begin
    {aclk, aresetn, clr, sync_request_input, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, f, n_fail, cmp_count} = '0;
    {lock_flag_in, vco_present_flag_in, reference_present_flag_in} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'hEC9080AA;
    cyc(3);
    aresetn <= 1'b1;
    cyc(1);
    rdc(8'h40, 32'h4, 2'h0);
    rdc(8'hFC, 32'h0, cod_pkg::RESP_SLVERR);
    wr(8'h08, 32'h0);
    for (t = 12; t < 24; t += 4) wr(8'(t), 32'h0);
    wr(8'h40, 32'h7);
    wr(8'h44, 32'h3);
    wr(8'h48, 32'h6);
    wr(8'hD0, 32'h1);
    e = int'(xs() % 4);
    for (t = 1; t >= 0; t--)
    begin
      wr(8'h18, 32'((e << 4) | (t << 1)));
      cyc(50);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      sync_request_input <= 1'b1;
      cyc(300);
      chk("pulses", cnt[0], t ? 1 << e : 0);
      chk("ignored", cnt[1], 0);
      chk("pass", clk_outs[2], 1);
      chk("aligned", clk_outs[4], clk_outs[3] ^ (t == 0));
      sync_request_input <= 1'b0;
    end
    $display("request test done");
    wr(8'h24, 32'h4);
    repeat (6)
    begin
      m = xs() & 32'h2A;
      f = 3'(xs());
      wr(8'h04, m);
      {lock_flag_in, vco_present_flag_in, reference_present_flag_in} <= f;
      cyc(12);
      chk("fault", fault_status, fx(m, f));
    end
    {lock_flag_in, vco_present_flag_in, reference_present_flag_in} <= 3'h0;
    wr(8'h04, 32'h2A);
    cyc(12);
    wr(8'h20, 32'h7);
    chk("irq idle", irq, 0);
    lock_flag_in <= 1'b1;
    cyc(12);
    chk("irq set", irq, 1);
    wr(8'h24, 32'h0);
    chk("irq masked", irq, 0);
    wr(8'h20, 32'h7);
    wr(8'h24, 32'h4);
    chk("irq cleared", irq, 0);
    $display("status test done");
    tally_and_finish();
  end
endmodule : clock_output_mode_delay_config_tb_top
`default_nettype wire
